// >>> wdtrf_watchdog.sv
// watchdog end: counter, modes, timed unlock, reset flags
// assumes osc tick and scan reset are async pins, fuse static
`timescale 1ns/10ps
`include "wdtrf_params.svh"
module wdtrf_watchdog (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic powerOnReset,
    input  wire logic oscTick,
    input  wire logic alwaysOnFuse,
    input  wire logic scanResetInstr,
    output logic      wakeRequest,
    wdtrf_if.wdog     bus
);
    import wdtrf_pkg::*;

    function automatic wdtrf_count_type limitOf(input wdtrf_sel_type s);
        wdtrf_sel_type c;
        c = (s > `WDTRF_SEL_MAX) ? `WDTRF_SEL_MAX : s;
        limitOf = `WDTRF_BASE_CYCLES << c;
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic [2:0]      oscSync;
    logic [1:0]      scanSync;
    logic            oscEdge;
    wdtrf_count_type watchdogCounter;
    logic            resetModeEnable;
    logic            irqModeEnable;
    logic            irqFlag;
    wdtrf_sel_type   timeoutSelect;
    logic [2:0]      unlockAge;
    logic            changeUnlock;
    logic            wdogResetFlag;
    logic            scanResetFlag;
    logic            scanSeen;
    logic            pulse;

    wire oscRise   = oscSync[1] & ~oscSync[2];
    wire effRste   = alwaysOnFuse | resetModeEnable | wdogResetFlag;
    wire effIrqe   = irqModeEnable & ~alwaysOnFuse;
    wire running   = effRste | effIrqe;
    wire [20:0] countNext = watchdogCounter + 21'h1;
    wire limitHit  = countNext >= limitOf(timeoutSelect);
    wire expire    = running & oscRise & limitHit;
    wire wrUnlock  = bus.wrCtrl & bus.wrData[`WDTRF_CTRL_UNLOCK_BIT]
                     & bus.wrData[`WDTRF_CTRL_RSTE_BIT];
    wire wrTimed   = bus.wrCtrl & ~bus.wrData[`WDTRF_CTRL_UNLOCK_BIT]
                     & changeUnlock;
    wire doReset   = expire & effRste & ~(effIrqe & ~irqFlag);
    wire doIrq     = expire & effIrqe & ~doReset;
    wire [3:0] newSel = {bus.wrData[`WDTRF_CTRL_SEL3_BIT],
                         bus.wrData[2:0]};
    wire wrIrqEnable = bus.wrData[`WDTRF_CTRL_IRQE_BIT];
    wire wrRste      = bus.wrData[`WDTRF_CTRL_RSTE_BIT];
    wire irqClear    = bus.irqAck |
                       (bus.wrCtrl & bus.wrData[`WDTRF_CTRL_IRQF_BIT]);
    wire wdogClear   = bus.wrStat & ~bus.wrData[`WDTRF_STAT_WDOG_BIT];
    wire scanClear   = bus.wrStat & ~bus.wrData[`WDTRF_STAT_SCAN_BIT];
    wire scanRise    = scanSync[1] & ~scanSeen;
    wire irqPending  = irqFlag | doIrq;
    wire [7:0] ctrlWord = {irqFlag, effIrqe, timeoutSelect[3],
                           changeUnlock, effRste, timeoutSelect[2:0]};
    wire [7:0] statWord = {3'h0, scanResetFlag, wdogResetFlag, 3'h0};

    ////////////////////////////////////////////////////////////////////
    // two-stage synchronisers for oscillator and scan pins
    always_ff @(posedge clk_sys) begin
        oscSync  <= {oscSync[1:0], oscTick};
        scanSync <= {scanSync[0], scanResetInstr};
    end

    // watchdog counter, cleared on restart or expiry
    always_ff @(posedge clk_sys) begin
        if (reset | bus.restart | expire | ~running) begin
            watchdogCounter <= '0;
        end else if (oscRise) begin
            watchdogCounter <= countNext;
        end
    end

    // timed unlock window
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            changeUnlock <= 1'b0;
            unlockAge    <= 3'h0;
        end else if (wrUnlock) begin
            changeUnlock <= 1'b1;
            unlockAge    <= 3'h0;
        end else if (changeUnlock) begin
            unlockAge    <= unlockAge + 3'h1;
            changeUnlock <= (unlockAge + 3'h1 < `WDTRF_UNLOCK_CYCLES)
                            & ~wrTimed;
        end
    end

    // mode enables and timeout select
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            resetModeEnable <= 1'b0;
            timeoutSelect   <= 4'h0;
            irqModeEnable   <= 1'b0;
        end else begin
            if (bus.wrCtrl) begin
                irqModeEnable <= wrIrqEnable;
            end else if (doIrq & effRste) begin
                irqModeEnable <= 1'b0;
            end
            if (wrUnlock) begin
                resetModeEnable <= 1'b1;
            end else if (wrTimed) begin
                resetModeEnable <= wrRste;
                timeoutSelect   <= newSel;
            end else if (bus.wrCtrl & wrRste) begin
                resetModeEnable <= 1'b1;
            end
        end
    end

    // interrupt flag, set beats clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irqFlag <= 1'b0;
        end else if (doIrq) begin
            irqFlag <= 1'b1;
        end else if (irqClear) begin
            irqFlag <= 1'b0;
        end
    end

    // internal reset pulse that sets the flag
    always_ff @(posedge clk_sys) begin
        pulse <= ~reset & doReset;
    end

    // scan request edge detector, idle low
    always_ff @(posedge clk_sys) begin
        if (powerOnReset) begin
            scanSeen <= 1'b0;
        end else begin
            scanSeen <= scanSync[1];
        end
    end

    // watchdog reset flag, set beats clear
    always_ff @(posedge clk_sys) begin
        if (powerOnReset) begin
            wdogResetFlag <= 1'b0;
        end else if (pulse) begin
            wdogResetFlag <= 1'b1;
        end else if (wdogClear) begin
            wdogResetFlag <= 1'b0;
        end
    end

    // scan reset flag, set beats clear
    always_ff @(posedge clk_sys) begin
        if (powerOnReset) begin
            scanResetFlag <= 1'b0;
        end else if (scanRise) begin
            scanResetFlag <= 1'b1;
        end else if (scanClear) begin
            scanResetFlag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // one-cycle reset request towards the core
    always_ff @(posedge clk_sys) begin
        bus.sysReset <= ~reset & doReset;
    end

    // interrupt request, shown only while interrupt mode holds
    always_ff @(posedge clk_sys) begin
        bus.irqReq <= ~reset & irqPending & effIrqe;
    end

    // wake request from sleep, follows the interrupt flag
    always_ff @(posedge clk_sys) begin
        wakeRequest <= ~reset & irqPending;
    end

    // control view, enable shown with flag override
    always_ff @(posedge clk_sys) begin
        bus.ctrlRead <= reset ? `WDTRF_CTRL_RESET : ctrlWord;
    end

    // status view, flags survive system reset
    always_ff @(posedge clk_sys) begin
        bus.statRead <= powerOnReset ? 8'h00 : statWord;
    end

endmodule // wdtrf_watchdog

// >>> wdtrf_params.svh
// constants of the watchdog timer with reset flags
// assumes inclusion by both ends
`ifndef WDTRF_PARAMS_SVH
`define WDTRF_PARAMS_SVH
`define WDTRF_CTRL_IRQF_BIT    7
`define WDTRF_CTRL_IRQE_BIT    6
`define WDTRF_CTRL_SEL3_BIT    5
`define WDTRF_CTRL_UNLOCK_BIT  4
`define WDTRF_CTRL_RSTE_BIT    3
`define WDTRF_STAT_SCAN_BIT    4
`define WDTRF_STAT_WDOG_BIT    3
`define WDTRF_CTRL_RESET       8'h00
`define WDTRF_UNLOCK_CYCLES    3'h4
`define WDTRF_SEL_MAX          4'h9
`define WDTRF_BASE_CYCLES      21'h000800
`define WDTRF_OSC_KHZ          128
`define WDTRF_SYS_KHZ          10000
`endif

// >>> wdtrf_pkg.sv
// types of the watchdog timer with reset flags
// assumes wdtrf_params.svh in the include path
package wdtrf_pkg;
    typedef logic [7:0]  wdtrf_byte_type;
    typedef logic [3:0]  wdtrf_sel_type;
    typedef logic [20:0] wdtrf_count_type;
    typedef enum logic [1:0] {
        WDTRF_OP_NONE,
        WDTRF_OP_CTRL,
        WDTRF_OP_STAT
    } wdtrf_op_type;
endpackage

// >>> wdtrf_if.sv
// interface joining core end and watchdog end
// assumes one system clock shared by both ends
`timescale 1ns/10ps
interface wdtrf_if;
    import wdtrf_pkg::*;
    logic           restart;
    logic           wrCtrl;
    logic           wrStat;
    wdtrf_byte_type wrData;
    wdtrf_byte_type ctrlRead;
    wdtrf_byte_type statRead;
    logic           irqReq;
    logic           irqAck;
    logic           sysReset;
    modport core (output restart, wrCtrl, wrStat, wrData, irqAck,
                  input ctrlRead, statRead, irqReq, sysReset);
    modport wdog (input restart, wrCtrl, wrStat, wrData, irqAck,
                  output ctrlRead, statRead, irqReq, sysReset);
endinterface

// >>> wdtrf_core.sv
// core end: restart, control writes, timed unlock sequence
// assumes a same-clock user issuing one command at a time
`timescale 1ns/10ps
`include "wdtrf_params.svh"
module wdtrf_core (
    input  wire logic                clk_sys,
    input  wire logic                reset,
    input  wire logic                cmdRestart,
    input  wire logic                cmdWrite,
    input  wire logic                cmdStat,
    input  wire logic                cmdProtected,
    input  wire wdtrf_pkg::wdtrf_byte_type cmdData,
    input  wire logic                cmdIrqAck,
    output logic                     busy,
    output wdtrf_pkg::wdtrf_byte_type ctrlView,
    output wdtrf_pkg::wdtrf_byte_type statView,
    wdtrf_if.core                    bus
);
    import wdtrf_pkg::*;

    ////////////////////////////////////////////////////////////////////
    wdtrf_byte_type held;
    logic           second;
    wire start = ~busy & cmdWrite & cmdProtected;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus.restart <= 1'b0;
            bus.wrCtrl  <= 1'b0;
            bus.wrStat  <= 1'b0;
            bus.wrData  <= 8'h00;
            bus.irqAck  <= 1'b0;
            busy        <= 1'b0;
            second      <= 1'b0;
            held        <= 8'h00;
        end else begin
            bus.irqAck  <= cmdIrqAck;
            bus.restart <= start | (~busy & cmdRestart);
            bus.wrStat  <= ~busy & cmdStat & ~cmdWrite;
            if (second) begin
                bus.wrCtrl <= 1'b1;
                bus.wrData <= held & ~(8'h01 << `WDTRF_CTRL_UNLOCK_BIT);
                second     <= 1'b0;
                busy       <= 1'b0;
            end else if (start) begin
                bus.wrCtrl <= 1'b1;
                bus.wrData <= (8'h01 << `WDTRF_CTRL_UNLOCK_BIT) |
                              (8'h01 << `WDTRF_CTRL_RSTE_BIT);
                held       <= cmdData;
                second     <= 1'b1;
                busy       <= 1'b1;
            end else begin
                bus.wrCtrl <= ~busy & cmdWrite & ~cmdStat;
                bus.wrData <= cmdData;
            end
            if (~busy & cmdStat & ~cmdWrite) begin
                bus.wrData <= cmdData;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        ctrlView <= reset ? 8'h00 : bus.ctrlRead;
        statView <= reset ? 8'h00 : bus.statRead;
    end

endmodule // wdtrf_core

// >>> wdtrf_asserts.sv
// checker of the link between core end and watchdog end
// assumes plain interface signals and one clock domain
`timescale 1ns/10ps
module wdtrf_asserts (
    input wire logic                      clk_sys,
    input wire logic                      reset,
    input wire logic                      wrCtrl,
    input wire wdtrf_pkg::wdtrf_byte_type wrData,
    input wire wdtrf_pkg::wdtrf_byte_type ctrlRead,
    input wire wdtrf_pkg::wdtrf_byte_type statRead,
    input wire logic                      irqReq,
    input wire logic                      irqAck,
    input wire logic                      sysReset
);
    import wdtrf_pkg::*;
    wire [3:0] selWr = {wrData[5], wrData[2:0]};
    wire [3:0] selRd = {ctrlRead[5], ctrlRead[2:0]};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////
    chk_pulse_one_cycle: assert property (sysReset |=> !sysReset)
        else $error("reset pulse too long");
    chk_flag_on_reset: assert property (sysReset |-> ##[1:3] statRead[3])
        else $error("reset flag not set");
    chk_flag_forces_enable: assert property (statRead[3] [*3] |-> ctrlRead[3])
        else $error("enable low with flag set");
    chk_unlock_self_clear: assert property ($rose(ctrlRead[4]) |-> ##[3:5] !ctrlRead[4])
        else $error("unlock not cleared");
    chk_locked_select: assert property (
        wrCtrl && !wrData[4] && !ctrlRead[4] && !$past(wrCtrl)
        |=> ##1 selRd == $past(selRd, 2))
        else $error("select changed while locked");
    chk_window_select: assert property (
        wrCtrl && !wrData[4] && $past(wrCtrl && wrData[4] && wrData[3])
        && selWr <= 4'h9 |=> ##1 selRd == $past(selWr, 2))
        else $error("select not taken in window");
    chk_irq_holds: assert property ((irqReq && !irqAck && !wrCtrl && !sysReset) [*2] |=> irqReq)
        else $error("interrupt dropped");
    chk_reset_needs_enable: assert property ($rose(sysReset) |-> $past(ctrlRead[3]))
        else $error("reset without enable");
    chk_irq_needs_enable: assert property ($rose(irqReq) |-> $past(ctrlRead[6]))
        else $error("interrupt without enable");
endmodule // wdtrf_asserts

// >>> test_watchdog_timer_with_reset_flags.sv
// testbench: core end and watchdog end joined over the interface
// assumes wdtrf_pkg compiled first; oscillator rises every 4 clocks
`timescale 1ns/10ps
module test_watchdog_timer_with_reset_flags;
    import wdtrf_pkg::*;
    localparam int SPAN = 2048 * 4;
    logic clk_sys, reset, pon, fuse, scan, rs, wr, st, pr, ack, busy, wake;
    logic [1:0] oscCnt = 2'h0;
    wdtrf_byte_type data, ctrlView, statView;
    int failures = 0, checks_done = 0, resets = 0, took;
    wdtrf_if bus ();
    wdtrf_watchdog i_wdtrf_watchdog (.clk_sys(clk_sys), .reset(reset),
        .powerOnReset(pon), .oscTick(oscCnt[1]), .alwaysOnFuse(fuse),
        .scanResetInstr(scan), .wakeRequest(wake), .bus(bus.wdog));
    wdtrf_core i_wdtrf_core (.clk_sys(clk_sys), .reset(reset),
        .cmdRestart(rs), .cmdWrite(wr), .cmdStat(st), .cmdProtected(pr),
        .cmdData(data), .cmdIrqAck(ack), .busy(busy),
        .ctrlView(ctrlView), .statView(statView), .bus(bus.core));
    wdtrf_asserts i_wdtrf_asserts (.clk_sys(clk_sys), .reset(reset),
        .wrCtrl(bus.wrCtrl), .wrData(bus.wrData), .ctrlRead(bus.ctrlRead),
        .statRead(bus.statRead), .irqReq(bus.irqReq), .irqAck(bus.irqAck),
        .sysReset(bus.sysReset));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        oscCnt <= oscCnt + 2'h1;
        if (bus.sysReset === 1'b1) resets <= resets + 1;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic compare(input wdtrf_byte_type got, exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic check_span(input int got, lo, hi);
        checks_done++;
        if (got < lo || got > hi) begin
            failures++;
            $display("unexpected at %0t: span %0d", $time, got);
        end
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic hang;
        failures++;
        $display("unexpected at %0t: timeout", $time);
        final_report();
    endtask
    task automatic issue(input logic r, w, s, p, input wdtrf_byte_type d);
        int n = 0;
        @(posedge clk_sys);
        {rs, wr, st, pr} <= {r, w, s, p};
        data <= d;
        @(posedge clk_sys);
        {rs, wr, st, pr} <= 4'h0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (busy !== 1'b0 && n < 20);
        if (n >= 20) hang();
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic wait_for(input bit onReset, input int limit);
        took = 0;
        do begin
            @(posedge clk_sys);
            #1 took++;
        end while ((onReset ? bus.sysReset : bus.irqReq) !== 1'b1
                   && took < limit);
        if (took >= limit) hang();
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_locked;
        compare(statView, 8'h00);
        issue(0, 1, 0, 0, 8'h05);
        compare(ctrlView, 8'h00);
        issue(0, 1, 0, 0, 8'h18);
        repeat (8) @(posedge clk_sys);
        issue(0, 1, 0, 0, 8'h03);
        compare(ctrlView, 8'h08);
    endtask
    task automatic t_irq_mode;
        issue(0, 1, 0, 1, 8'h40);
        compare(ctrlView, 8'h40);
        wait_for(0, SPAN + 200);
        check_span(took, SPAN - 40, SPAN + 20);
        compare({7'h00, wake}, 8'h01);
        @(posedge clk_sys);
        ack <= 1'b1;
        @(posedge clk_sys);
        ack <= 1'b0;
        repeat (4) @(posedge clk_sys);
        compare({7'h00, bus.irqReq}, 8'h00);
        compare(resets[7:0], 8'h00);
    endtask
    task automatic t_restart;
        repeat (3) begin
            issue(1, 0, 0, 0, 8'h00);
            repeat (6000) @(posedge clk_sys);
        end
        compare({7'h00, bus.irqReq}, 8'h00);
    endtask
    task automatic t_combined;
        issue(0, 1, 0, 1, 8'h48);
        wait_for(0, SPAN + 200);
        compare(resets[7:0], 8'h00);
        wait_for(1, SPAN + 200);
        check_span(took, SPAN - 20, SPAN + 20);
        repeat (4) @(posedge clk_sys);
        compare(statView, 8'h08);
        reset <= 1'b1;
        @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        compare(ctrlView, 8'h08);
    endtask
    task automatic t_clear_flag;
        issue(0, 1, 0, 1, 8'h00);
        compare(ctrlView, 8'h08);
        issue(0, 0, 1, 0, 8'h00);
        compare(statView, 8'h00);
        issue(0, 1, 0, 1, 8'h21);
        compare(ctrlView, 8'h21);
        issue(0, 1, 0, 1, 8'h00);
        compare(ctrlView, 8'h00);
    endtask
    task automatic t_scan_fuse;
        scan <= 1'b1;
        repeat (10) @(posedge clk_sys);
        scan <= 1'b0;
        repeat (4) @(posedge clk_sys);
        compare(statView, 8'h10);
        issue(0, 0, 1, 0, 8'h00);
        compare(statView, 8'h00);
        {fuse, reset} <= 2'h3;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        issue(0, 1, 0, 1, 8'h40);
        compare(ctrlView & 8'h48, 8'h08);
    endtask
    initial begin
        {reset, pon} = 2'h3;
        {fuse, scan, rs, wr, st, pr, ack} = 7'h00;
        data = 8'h00;
        repeat (3) @(posedge clk_sys);
        {reset, pon} <= 2'h0;
        repeat (3) @(posedge clk_sys);
        t_locked();
        t_irq_mode();
        t_restart();
        t_combined();
        t_clear_flag();
        t_scan_fuse();
        final_report();
    end
endmodule // test_watchdog_timer_with_reset_flags
